/* logic/ascc_pkg.sv */
`default_nettype none
package ascc_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;
    // Settling time added per step of the capacitor code
    localparam int SETTLE_UNIT_NS = 100;
    localparam logic [11:0] SETTLE_UNIT_CYC =
        12'((SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] SETTLE_BASE_CYC = 12'h001;
    // Master clock rising edges per conversion
    localparam logic [4:0] CONV_MCLK_EDGES = 5'h0e;

    // ****************************************
    // Serial framing
    // ****************************************
    localparam int WORD_BITS = 16;
    localparam logic [4:0] WORD_FALLS = 5'h10;
    localparam logic [2:0] CTRL_BITS = 3'h5;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam int ADDR_MSB = 4;
    localparam int ADDR_LSB = 2;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ASCC_IDLE = 2'b00,
        ASCC_PEND = 2'b01,
        ASCC_CONV = 2'b10
    } ascc_conv_state_t;

    // Pins from outside the clock domain
    typedef struct packed {
        logic mode_n;
        logic trig;
        logic mclk;
        logic sclk;
        logic rfs_n;
        logic tfs_n;
        logic din;
    } ascc_pins_t;

    localparam ascc_pins_t PINS_IDLE = '{mode_n: 1'b1, trig: 1'b0, mclk: 1'b0,
        sclk: 1'b1, rfs_n: 1'b1, tfs_n: 1'b1, din: 1'b0};
endpackage
`default_nettype wire

/* logic/ascc_convert_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Mode low: drive serial clock, receive sync
// - Mode high: serial clock, receive sync external
// - Trigger rise holds and converts if settled
// - Trigger during settling waits for its end
// - Conversion timed from master clock edges
// - Master serial clock derived from master clock
// - Slave shifts both ways on external clock
// - Master uses own clock for both directions
// - Capacitor code sets settling pulse length
// - Sixteen bits: zero, address, twelve data
// - First five falls after transmit sync load
// - Receive sync frames output, transmit sync input
module ascc_convert_ctrl
    import ascc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_master_select_n,
    input wire logic conversion_trigger,
    input wire logic master_clk_pin,
    input wire logic [7:0] settle_capacitor_pin,
    input wire logic [11:0] adc_sample,
    input wire logic serial_clk_in,
    output logic serial_clk_out,
    output logic serial_clk_oe,
    input wire logic receive_frame_sync_n_in,
    output logic receive_frame_sync_n_out,
    output logic receive_frame_sync_n_oe,
    input wire logic transmit_frame_sync_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    output logic hold_active,
    output logic settle_active,
    output logic [2:0] channel_select
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    ascc_pins_t pin_meta_reg, pin_sync_reg, pin_prev_reg;
    ascc_pins_t pin_raw;
    logic [7:0] cap_meta_reg, cap_sync_reg;

    always_comb begin
        pin_raw = '{mode_n: serial_master_select_n, trig: conversion_trigger,
            mclk: master_clk_pin, sclk: serial_clk_in, rfs_n: receive_frame_sync_n_in,
            tfs_n: transmit_frame_sync_n, din: serial_data_in};
    end

    // Capacitor code is static; two stages only guard against metastability
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_reg <= PINS_IDLE;
            pin_sync_reg <= PINS_IDLE;
            pin_prev_reg <= PINS_IDLE;
            cap_meta_reg <= 8'h00;
            cap_sync_reg <= 8'h00;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
            cap_meta_reg <= settle_capacitor_pin;
            cap_sync_reg <= cap_meta_reg;
        end
    end

    // ****************************************
    // Conversion and settling
    // ****************************************
    ascc_conv_state_t conv_state_reg, conv_state_next;
    logic [4:0] mclk_cnt_reg, mclk_cnt_next;
    logic [11:0] settle_cnt_reg, settle_cnt_next;
    logic settle_flag_reg, settle_flag_next;
    logic hold_reg, hold_next;
    logic [15:0] result_reg, result_next;
    logic [4:0] ctrl_reg, ctrl_next;
    logic mode_master_reg, mode_master_next;
    logic trig_rise, mclk_rise, conv_done, ctrl_loaded;

    always_comb begin
        trig_rise = pin_sync_reg.trig & ~pin_prev_reg.trig;
        mclk_rise = pin_sync_reg.mclk & ~pin_prev_reg.mclk;
        mode_master_next = ~pin_sync_reg.mode_n;
        conv_state_next = conv_state_reg;
        mclk_cnt_next = mclk_cnt_reg;
        hold_next = hold_reg;
        result_next = result_reg;
        conv_done = 1'b0;
        settle_cnt_next = settle_cnt_reg;
        if (ctrl_loaded) begin
            // Mux changed: give the external filter time to settle
            settle_cnt_next = ({4'h0, cap_sync_reg} * SETTLE_UNIT_CYC) + SETTLE_BASE_CYC;
        end else if (settle_cnt_reg != 12'h000) begin
            settle_cnt_next = settle_cnt_reg - 12'h001;
        end
        // Registered so the settling output comes straight from a flop
        settle_flag_next = (settle_cnt_next != 12'h000);
        unique case (conv_state_reg)
            ASCC_IDLE: begin
                if (trig_rise) begin
                    conv_state_next = ASCC_PEND;
                end
            end
            ASCC_PEND: begin
                if (settle_cnt_reg == 12'h000) begin
                    conv_state_next = ASCC_CONV;
                    hold_next = 1'b1;
                    mclk_cnt_next = 5'h00;
                end
            end
            ASCC_CONV: begin
                if (mclk_rise) begin
                    mclk_cnt_next = mclk_cnt_reg + 5'h01;
                    if (mclk_cnt_reg == CONV_MCLK_EDGES - 5'h01) begin
                        conv_state_next = ASCC_IDLE;
                        hold_next = 1'b0;
                        conv_done = 1'b1;
                        result_next = {1'b0, ctrl_reg[ADDR_MSB:ADDR_LSB], adc_sample};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            conv_state_reg <= ASCC_IDLE;
            mclk_cnt_reg <= 5'h00;
            settle_cnt_reg <= 12'h000;
            settle_flag_reg <= 1'b0;
            hold_reg <= 1'b0;
            result_reg <= RESULT_RESET;
            mode_master_reg <= 1'b0;
        end else begin
            conv_state_reg <= conv_state_next;
            mclk_cnt_reg <= mclk_cnt_next;
            settle_cnt_reg <= settle_cnt_next;
            settle_flag_reg <= settle_flag_next;
            hold_reg <= hold_next;
            result_reg <= result_next;
            mode_master_reg <= mode_master_next;
        end
    end

    // ****************************************
    // Serial port
    // ****************************************
    logic sclk_out_reg, sclk_out_next;
    logic sclk_prev_reg, sclk_prev_next;
    logic mframe_reg, mframe_next;
    logic oe_reg, oe_next;
    logic dout_reg, dout_next;
    logic [15:0] shift_reg, shift_next;
    logic [4:0] fall_cnt_reg, fall_cnt_next;
    logic [4:0] ctrl_shift_reg, ctrl_shift_next;
    logic [2:0] ctrl_cnt_reg, ctrl_cnt_next;
    logic sclk_level, sclk_rise, sclk_fall, frame_on, frame_start;

    always_comb begin
        // Own clock in master mode, partner's in slave mode
        sclk_level = mode_master_reg ? sclk_out_reg : pin_sync_reg.sclk;
        sclk_rise = sclk_level & ~sclk_prev_reg;
        sclk_fall = ~sclk_level & sclk_prev_reg;
        sclk_prev_next = sclk_level;
        frame_on = mode_master_reg ? mframe_reg : ~pin_sync_reg.rfs_n;
        frame_start = mode_master_reg ? (conv_done & ~mframe_reg)
                                      : (~pin_sync_reg.rfs_n & pin_prev_reg.rfs_n);
        mframe_next = mframe_reg;
        if (mode_master_reg && conv_done) begin
            mframe_next = 1'b1;
        end else if (!mode_master_reg || (fall_cnt_reg == WORD_FALLS && sclk_rise)) begin
            mframe_next = 1'b0;
        end
        // Serial clock follows the master clock level while framed
        sclk_out_next = (mode_master_reg && mframe_reg) ? pin_sync_reg.mclk : 1'b1;
        shift_next = shift_reg;
        dout_next = dout_reg;
        oe_next = oe_reg;
        fall_cnt_next = fall_cnt_reg;
        if (frame_start) begin
            // Master frame opens on the last conversion edge: take the fresh word
            shift_next = result_next;
            dout_next = result_next[WORD_BITS-1];
            oe_next = 1'b1;
            fall_cnt_next = 5'h00;
        end else if (!frame_on) begin
            oe_next = 1'b0;
        end else begin
            if (sclk_fall && fall_cnt_reg != WORD_FALLS) begin
                fall_cnt_next = fall_cnt_reg + 5'h01;
            end
            // Next bit moves on the rising edge so it is steady at the fall
            if (sclk_rise && fall_cnt_reg != 5'h00) begin
                shift_next = {shift_reg[WORD_BITS-2:0], 1'b0};
                dout_next = shift_reg[WORD_BITS-2];
                if (fall_cnt_reg == WORD_FALLS) begin
                    oe_next = 1'b0;
                end
            end
        end
        ctrl_shift_next = ctrl_shift_reg;
        ctrl_cnt_next = ctrl_cnt_reg;
        ctrl_next = ctrl_reg;
        ctrl_loaded = 1'b0;
        if (pin_sync_reg.tfs_n) begin
            ctrl_cnt_next = 3'h0;
        end else if (sclk_fall && ctrl_cnt_reg != CTRL_BITS) begin
            ctrl_shift_next = {ctrl_shift_reg[3:0], pin_sync_reg.din};
            ctrl_cnt_next = ctrl_cnt_reg + 3'h1;
            if (ctrl_cnt_reg == CTRL_BITS - 3'h1) begin
                ctrl_next = {ctrl_shift_reg[3:0], pin_sync_reg.din};
                ctrl_loaded = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_out_reg <= 1'b1;
            sclk_prev_reg <= 1'b1;
            mframe_reg <= 1'b0;
            oe_reg <= 1'b0;
            dout_reg <= 1'b0;
            shift_reg <= RESULT_RESET;
            fall_cnt_reg <= 5'h00;
            ctrl_shift_reg <= CTRL_RESET;
            ctrl_cnt_reg <= 3'h0;
            ctrl_reg <= CTRL_RESET;
        end else begin
            sclk_out_reg <= sclk_out_next;
            sclk_prev_reg <= sclk_prev_next;
            mframe_reg <= mframe_next;
            oe_reg <= oe_next;
            dout_reg <= dout_next;
            shift_reg <= shift_next;
            fall_cnt_reg <= fall_cnt_next;
            ctrl_shift_reg <= ctrl_shift_next;
            ctrl_cnt_reg <= ctrl_cnt_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_comb begin
        serial_clk_out = sclk_out_reg;
        serial_clk_oe = mode_master_reg;
        receive_frame_sync_n_out = ~mframe_reg;
        receive_frame_sync_n_oe = mode_master_reg;
        serial_data_out = dout_reg;
        serial_data_oe = oe_reg;
        hold_active = hold_reg;
        settle_active = settle_flag_reg;
        channel_select = ctrl_reg[ADDR_MSB:ADDR_LSB];
    end
endmodule // ascc_convert_ctrl
`default_nettype wire

/* testbench/ascc_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module ascc_assertions
    import ascc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_master_select_n,
    input wire logic conversion_trigger,
    input wire logic master_clk_pin,
    input wire logic [7:0] settle_capacitor_pin,
    input wire logic [11:0] adc_sample,
    input wire logic serial_clk_in,
    input wire logic serial_clk_out,
    input wire logic serial_clk_oe,
    input wire logic receive_frame_sync_n_in,
    input wire logic receive_frame_sync_n_out,
    input wire logic receive_frame_sync_n_oe,
    input wire logic transmit_frame_sync_n,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    input wire logic hold_active,
    input wire logic settle_active,
    input wire logic [2:0] channel_select
);
    // ****
    // Length counters
    // ****
    logic [11:0] settle_cnt_reg, settle_cnt_next;
    logic [4:0] edge_cnt_reg, edge_cnt_next;
    logic mclk_reg, mclk_next;
    always_comb begin
        settle_cnt_next = settle_active ? settle_cnt_reg + 12'h001 : 12'h000;
        edge_cnt_next = hold_active ? edge_cnt_reg + 5'(master_clk_pin & ~mclk_reg) : 5'h00;
        mclk_next = master_clk_pin;
    end
    always_ff @(posedge clk) begin
        settle_cnt_reg <= rst ? 12'h000 : settle_cnt_next;
        edge_cnt_reg <= rst ? 5'h00 : edge_cnt_next;
        mclk_reg <= mclk_next;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence mode_low_s; !serial_master_select_n [*6]; endsequence
    sequence mode_high_s; serial_master_select_n [*6]; endsequence
    sequence clean_trig_s; !settle_active && !hold_active && $rose(conversion_trigger); endsequence
    // Pin edges are seen late, so one edge either way
    a_master_pins: assert property (mode_low_s |-> serial_clk_oe && receive_frame_sync_n_oe)
        else $error("master pins not driven");
    a_slave_pins: assert property (mode_high_s |-> !serial_clk_oe && !receive_frame_sync_n_oe)
        else $error("slave pins driven");
    a_trig_hold: assert property (clean_trig_s |-> ##[2:5] hold_active)
        else $error("hold late after trigger");
    a_settle_first: assert property ($rose(hold_active) |-> !$past(settle_active))
        else $error("hold during settling");
    a_conv_len: assert property ($fell(hold_active) |-> edge_cnt_reg inside {[5'd13:5'd15]})
        else $error("conversion length wrong");
    a_sclk_idle: assert property (serial_clk_oe && receive_frame_sync_n_out |-> serial_clk_out)
        else $error("serial clock runs outside frame");
    a_settle_len: assert property ($fell(settle_active) |->
        settle_cnt_reg == 12'(settle_capacitor_pin) * SETTLE_UNIT_CYC + SETTLE_BASE_CYC)
        else $error("settle length wrong");
    a_lead_zero: assert property ($rose(serial_data_oe) |-> !serial_data_out)
        else $error("first bit not zero");
    a_ctrl_framed: assert property ($changed(channel_select) |-> !$past(transmit_frame_sync_n, 4))
        else $error("control changed outside frame");
    a_sync_oe: assert property (serial_clk_oe == receive_frame_sync_n_oe)
        else $error("enables disagree");
endmodule // ascc_assertions
bind ascc_convert_ctrl ascc_assertions ascc_assertions_i (.*);
`default_nettype wire

/* testbench/ascc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ascc_host_model (
    input wire logic clk_in,
    input wire logic fs_in,
    input wire logic dout,
    output logic sclk_drv,
    output logic fs_n,
    output logic din
);
    initial begin
        sclk_drv = 1'b1;
        fs_n = 1'b1;
        din = 1'b0;
    end
    // Bounded wait for a level of the serial clock
    task automatic wait_lvl(input logic v, inout logic tmo);
        int j;
        for (j = 0; j < 4000 && clk_in !== v; j++) #1;
        if (j == 4000) tmo = 1'b1;
    endtask
    // Slave frames at 64 ns; master frames follow the device clock
    task automatic xfer(input logic slave, input logic [4:0] c, input int n,
        output logic [15:0] w, output logic tmo);
        int i;
        tmo = 1'b0;
        din = c[4];
        w = 16'h0000;
        if (slave) begin
            fs_n = 1'b0;
            #40;
        end
        for (i = 0; i < 4000 && fs_in; i++) #8;
        if (i == 4000) tmo = 1'b1;
        for (i = 0; i < n; i++) begin
            if (slave) sclk_drv = 1'b0;
            else wait_lvl(1'b0, tmo);
            #(slave ? 32 : 4);
            w = {w[14:0], dout};
            if (slave) begin
                sclk_drv = 1'b1;
            end else begin
                wait_lvl(1'b1, tmo);
                #1;
            end
            din = (i < 4) ? c[3 - i] : ~din;
            if (slave) #32;
        end
        fs_n = 1'b1;
        din = ~din; // Stale level never passes for a bit
    endtask
endmodule // ascc_host_model
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import ascc_pkg::*;
;
    logic clk, rst, serial_master_select_n, conversion_trigger, master_clk_pin;
    logic [7:0] settle_capacitor_pin;
    logic [11:0] adc_sample;
    logic serial_clk_out, serial_clk_oe, receive_frame_sync_n_out, receive_frame_sync_n_oe;
    logic serial_data_out, serial_data_oe, hold_active, settle_active;
    logic host_sclk, host_fs_n, host_din;
    logic [2:0] channel_select;
    logic [31:0] seed = 32'h12;
    int err_count = 0;
    int compares = 0;
    wire serial_clk_in = serial_clk_oe ? serial_clk_out : host_sclk;
    wire receive_frame_sync_n_in = receive_frame_sync_n_oe ? receive_frame_sync_n_out : host_fs_n;
    wire transmit_frame_sync_n = receive_frame_sync_n_in;
    wire serial_data_in = host_din;
    // Released data line has no pull: the model sees the inverse of the last bit
    wire host_dout = serial_data_oe ? serial_data_out : ~serial_data_out;
    ascc_convert_ctrl ascc_convert_ctrl_i (
        .clk(clk),
        .rst(rst),
        .serial_master_select_n(serial_master_select_n),
        .conversion_trigger(conversion_trigger),
        .master_clk_pin(master_clk_pin),
        .settle_capacitor_pin(settle_capacitor_pin),
        .adc_sample(adc_sample),
        .serial_clk_in(serial_clk_in),
        .serial_clk_out(serial_clk_out),
        .serial_clk_oe(serial_clk_oe),
        .receive_frame_sync_n_in(receive_frame_sync_n_in),
        .receive_frame_sync_n_out(receive_frame_sync_n_out),
        .receive_frame_sync_n_oe(receive_frame_sync_n_oe),
        .transmit_frame_sync_n(transmit_frame_sync_n),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe),
        .hold_active(hold_active),
        .settle_active(settle_active),
        .channel_select(channel_select)
    );
    ascc_host_model ascc_host_model_i (.clk_in(serial_clk_in), .fs_in(receive_frame_sync_n_in),
        .dout(host_dout), .sclk_drv(host_sclk), .fs_n(host_fs_n), .din(host_din));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        master_clk_pin = 1'b0;
        #3;
        forever #24 master_clk_pin = ~master_clk_pin;
    end
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] exp_word(input logic [2:0] a, input logic [11:0] d);
        return {1'b0, a, d};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic host_xfer(input logic s, input logic [4:0] c, input int n,
        output logic [15:0] w);
        logic tmo;
        ascc_host_model_i.xfer(s, c, n, w, tmo);
        if (tmo) begin
            err_count++;
            wrap_up();
        end
    endtask
    task automatic wait_hold(input logic v);
        int i;
        for (i = 0; i < 5000 && hold_active !== v; i++) tick(1);
        if (i == 5000) begin
            err_count++;
            wrap_up();
        end
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        logic [15:0] w, e;
        logic [4:0] c;
        int k;
        rst = 1'b1;
        serial_master_select_n = 1'b1;
        conversion_trigger = 1'b0;
        settle_capacitor_pin = 8'h00;
        adc_sample = 12'h000;
        tick(2);
        rst = 1'b0;
        tick(3);
        chk("reset", 16'h0006, {hold_active, settle_active, channel_select, serial_data_oe,
            serial_clk_out, receive_frame_sync_n_out, serial_clk_oe});
        $display("reset test done");
        e = RESULT_RESET;
        for (k = 0; k < 5; k++) begin
            c = 5'(rnd());
            settle_capacitor_pin = (k == 0) ? 8'h00 : (k == 4) ? 8'hff : 8'h10 + 8'(rnd() % 16);
            adc_sample = 12'(rnd());
            host_xfer(1'b1, c, 16, w);
            chk("slave word", e, w);
            tick(6);
            chk("channel", 16'(c[4:2]), 16'(channel_select));
            conversion_trigger = 1'b1;
            tick(6);
            chk("hold state", (k == 0) ? 16'h1 : 16'h2, {14'h0, settle_active, hold_active});
            wait_hold(1'b1);
            wait_hold(1'b0);
            conversion_trigger = 1'b0;
            e = exp_word(c[4:2], adc_sample);
            $display("slave test %0d done", k);
        end
        host_xfer(1'b1, ~c, 3, w);
        tick(6);
        chk("partial load", 16'(c[4:2]), 16'(channel_select));
        $display("partial load test done");
        serial_master_select_n = 1'b0;
        settle_capacitor_pin = 8'h01;
        tick(6);
        chk("master oe", 16'h3, {14'h0, serial_clk_oe, receive_frame_sync_n_oe});
        e[14:12] = c[4:2];
        c = 5'(rnd());
        adc_sample = 12'(rnd());
        e[11:0] = adc_sample;
        conversion_trigger = 1'b1;
        host_xfer(1'b0, c, 16, w);
        chk("master word", e, w);
        tick(10);
        chk("master channel", 16'(c[4:2]), 16'(channel_select));
        conversion_trigger = 1'b0;
        $display("master test done");
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
